// ===== common/mid_params.svh
// What this block does
// - sample and decode pending flags every clock
// - fastest response is detect plus four-clock call
// - after return one instruction runs before call
// - worst unblocked response is eighteen clocks
// - equal or lower level waits past return
// - fixed vectors from 0x0003 in eight-byte steps
// - equal level ties go to lower index
// - per-source enable and level; reset vectors zero
// - primary enable register resets to zero
// - global enable gates every source
// - edge external flags cleared on vectoring
// - high preempts low; high never preempted
// - flag still set after return re-requests
`ifndef MID_PARAMS_SVH
`define MID_PARAMS_SVH
`define MID_NSRC          15
`define MID_VEC_BASE      16'h0003
`define MID_VEC_STEP      16'h0008
`define MID_VEC_RESET     16'h0000
`define MID_IEP_RESET     8'h00
`define MID_IEP_GLOBAL    7
`define MID_SRC_EXT0      0
`define MID_SRC_EXT1      2
`define MID_RSVD_MASK     15'h2100
`define MID_DETECT_CYC    1
`define MID_CALL_CYC      4
`define MID_MIN_RESP_CYC  5
`define MID_MAX_RESP_CYC  18
`endif

// ===== common/mid_pkg.sv
`default_nettype none
package mid_pkg;
  typedef logic [15:0] mid_vec_t;
  typedef enum logic [1:0] {MID_IDLE, MID_AFTER_RET, MID_CALL} mid_state_e;
endpackage : mid_pkg
`default_nettype wire

// ===== src/mid_dispatch.sv
`include "mid_params.svh"
`default_nettype none
module mid_dispatch #(
  parameter int NSRC = `MID_NSRC
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // primary enable register port
  input  wire logic               iep_wr,
  input  wire logic [7:0]         iep_wdata,
  output logic      [7:0]         iep_rdata,
  // extended enables and priority bits
  input  wire logic [NSRC-1:0]    src_enable_ext,
  input  wire logic [NSRC-1:0]    src_prio_high,
  // pending flags from peripherals
  input  wire logic [NSRC-1:0]    src_pending,
  input  wire logic               ext0_edge_mode,
  input  wire logic               ext1_edge_mode,
  output logic                    ext_input0_pending_clr,
  output logic                    ext_input1_pending_clr,
  // core sequencer handshake
  input  wire logic               instr_done,
  input  wire logic               return_from_interrupt,
  input  wire logic               long_call_done,
  output logic                    long_call_req,
  output mid_pkg::mid_vec_t       service_routine_vec,
  output logic [1:0]              active_level
);
  // primary enable: bits 6..0 map to sources 0..6, bit 7 global
  logic [7:0] iep_ff, nxt_iep;
  mid_pkg::mid_state_e state_ff, nxt_state;
  logic [1:0] act_ff, nxt_act;          // bit1 high active, bit0 low
  // reserved slots never raise a request
  localparam logic [NSRC-1:0] RSVD_MASK = NSRC'(`MID_RSVD_MASK);
  logic [3:0] win_ff, nxt_win;
  logic       win_hi_ff, nxt_win_hi;
  mid_pkg::mid_vec_t vec_ff, nxt_vec;
  logic       clr0_ff, nxt_clr0, clr1_ff, nxt_clr1;
  logic [NSRC-1:0] en_all, req;
  logic [3:0] hi_idx, lo_idx;
  logic       hi_any, lo_any, take, take_hi;
  logic [3:0] take_idx;

  always_comb begin
    nxt_iep = iep_ff;
    if (iep_wr) begin
      nxt_iep = iep_wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      iep_ff <= `MID_IEP_RESET;
    end else begin
      iep_ff <= nxt_iep;
    end
  end
  assign iep_rdata = iep_ff;

  // per-source gating by global enable
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_req
      if (g < 7) begin : g_pri
        assign en_all[g] = iep_ff[g];
      end else begin : g_ext
        assign en_all[g] = src_enable_ext[g];
      end
      assign req[g] = src_pending[g] & en_all[g] & iep_ff[`MID_IEP_GLOBAL]
                    & ~RSVD_MASK[g];
    end
  endgenerate

  // fixed order: lowest index wins within a level
  always_comb begin
    hi_any = 1'b0;
    lo_any = 1'b0;
    hi_idx = 4'h0;
    lo_idx = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i] && src_prio_high[i]) begin
        hi_any = 1'b1;
        hi_idx = 4'(i);
      end
      if (req[i] && !src_prio_high[i]) begin
        lo_any = 1'b1;
        lo_idx = 4'(i);
      end
    end
  end

  // preemption: high beats running low, nothing beats high
  always_comb begin
    take_hi  = hi_any && !act_ff[1];
    take     = take_hi || (lo_any && act_ff == 2'b00);
    take_idx = take_hi ? hi_idx : lo_idx;
  end

  // decode every cycle; call after current instruction
  always_comb begin
    nxt_state  = state_ff;
    nxt_act    = act_ff;
    nxt_win    = win_ff;
    nxt_win_hi = win_hi_ff;
    nxt_vec    = vec_ff;
    nxt_clr0   = 1'b0;
    nxt_clr1   = 1'b0;
    unique case (state_ff)
      mid_pkg::MID_IDLE: begin
        if (return_from_interrupt) begin
          // drop the innermost level, then one more instruction
          if (act_ff[1]) begin
            nxt_act[1] = 1'b0;
          end else begin
            nxt_act[0] = 1'b0;
          end
          nxt_state = mid_pkg::MID_AFTER_RET;
        end else if (take && instr_done) begin
          nxt_state  = mid_pkg::MID_CALL;
          nxt_win    = take_idx;
          nxt_win_hi = take_hi;
          nxt_vec    = `MID_VEC_BASE + 16'(take_idx) * `MID_VEC_STEP;
        end
      end
      mid_pkg::MID_AFTER_RET: begin
        // the one instruction after a return ends: call a waiting source
        if (instr_done && take) begin
          nxt_state  = mid_pkg::MID_CALL;
          nxt_win    = take_idx;
          nxt_win_hi = take_hi;
          nxt_vec    = `MID_VEC_BASE + 16'(take_idx) * `MID_VEC_STEP;
        end else if (instr_done) begin
          nxt_state = mid_pkg::MID_IDLE;
        end
      end
      mid_pkg::MID_CALL: begin
        if (long_call_done) begin
          nxt_state = mid_pkg::MID_IDLE;
          if (win_hi_ff) begin
            nxt_act[1] = 1'b1;
          end else begin
            nxt_act[0] = 1'b1;
          end
          nxt_clr0 = ext0_edge_mode && win_ff == 4'(`MID_SRC_EXT0);
          nxt_clr1 = ext1_edge_mode && win_ff == 4'(`MID_SRC_EXT1);
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff  <= mid_pkg::MID_IDLE;
      act_ff    <= 2'b00;
      win_ff    <= 4'h0;
      win_hi_ff <= 1'b0;
      vec_ff    <= `MID_VEC_RESET;
      clr0_ff   <= 1'b0;
      clr1_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      act_ff    <= nxt_act;
      win_ff    <= nxt_win;
      win_hi_ff <= nxt_win_hi;
      vec_ff    <= nxt_vec;
      clr0_ff   <= nxt_clr0;
      clr1_ff   <= nxt_clr1;
    end
  end

  assign long_call_req          = (state_ff == mid_pkg::MID_CALL);
  assign service_routine_vec    = vec_ff;
  assign active_level           = act_ff;
  assign ext_input0_pending_clr = clr0_ff;
  assign ext_input1_pending_clr = clr1_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  AST_GLOBAL_OFF: assert property (
    !iep_ff[`MID_IEP_GLOBAL] && state_ff == mid_pkg::MID_IDLE
    |=> state_ff != mid_pkg::MID_CALL)
    else $error("call taken with global enable off");
  AST_CALL_NEXT: assert property (
    state_ff == mid_pkg::MID_IDLE && !return_from_interrupt && take
    && instr_done |=> long_call_req)
    else $error("call not raised one cycle after detect");
  AST_RET_WAIT: assert property (
    state_ff == mid_pkg::MID_IDLE && return_from_interrupt
    |=> !long_call_req ##0 state_ff == mid_pkg::MID_AFTER_RET)
    else $error("call issued without one instruction after return");
  AST_HI_NOPREEMPT: assert property (
    act_ff[1] && state_ff == mid_pkg::MID_IDLE && !return_from_interrupt
    |=> !long_call_req)
    else $error("high level routine preempted");
  AST_VEC_MAP: assert property (
    long_call_req |-> vec_ff == 16'h0003 + 16'(win_ff) * 16'h0008)
    else $error("vector does not match winner");
  AST_PRIO_TIE: assert property (
    state_ff == mid_pkg::MID_IDLE && take && instr_done
    && !return_from_interrupt && req[0] && src_prio_high[0] == take_hi
    |=> win_ff == 4'h0)
    else $error("lower index lost tie");
  AST_EDGE_CLR: assert property (
    long_call_req && long_call_done && win_ff == 4'h0 && ext0_edge_mode
    |=> ext_input0_pending_clr ##1 !ext_input0_pending_clr)
    else $error("edge flag not cleared on vectoring");
  AST_LEVEL_SET: assert property (
    long_call_req && long_call_done && win_hi_ff |=> act_ff[1])
    else $error("active level not tracked");
  AST_RSVD: assert property (
    long_call_req |-> win_ff != 4'h8 && win_ff != 4'hd)
    else $error("reserved slot vectored");
  AST_RET_CALL: assert property (
    state_ff == mid_pkg::MID_AFTER_RET && instr_done && take
    |=> long_call_req)
    else $error("call not made after one instruction past return");
  AST_RET_HOLD: assert property (
    state_ff == mid_pkg::MID_AFTER_RET && !instr_done
    |=> !long_call_req)
    else $error("call made before instruction after return ended");

  COV_LOW_CALL: cover property (long_call_req && !win_hi_ff);
  COV_PREEMPT: cover property (act_ff == 2'b01 && long_call_req
    && win_hi_ff);
  COV_RET_RECALL: cover property (state_ff == mid_pkg::MID_AFTER_RET
    ##1 long_call_req);
  COV_EDGE_CLR: cover property (ext_input1_pending_clr);
endmodule // mid_dispatch
`default_nettype wire

// ===== dv/mid_cpu_model.sv
`default_nettype none
module mid_cpu_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // call handshake with the dispatcher
  input  wire logic       long_call_req,
  input  wire logic [3:0] call_len,
  output logic            long_call_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_ff;
  // done closes a call of call_len clocks counted from the request
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !long_call_req || long_call_done) begin
      cnt_ff         <= 4'h0;
      long_call_done <= 1'b0;
    end else begin
      cnt_ff         <= cnt_ff + 4'h1;
      long_call_done <= (cnt_ff == call_len - 4'h2);
    end
  end
endmodule // mid_cpu_model
`default_nettype wire

// ===== dv/mid_dispatch_tb_top.sv
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module mid_dispatch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, iep_wr = 1'b0;
  logic        instr_done = 1'b0, rfi = 1'b0, edge_m = 1'b1;
  logic        req, done, clr0, clr1;
  logic [7:0]  iep_wdata = 8'h00, iep_rdata;
  logic [14:0] pend = 15'h0000, prio = 15'h0000, ext_en = 15'h7fff;
  logic [15:0] vec;
  logic [1:0]  lvl;
  logic [3:0]  call_len = 4'h4;
  int          miscompares = 0, checked = 0, cyc = 0;
  mid_dispatch DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .iep_wr(iep_wr),
    .iep_wdata(iep_wdata), .iep_rdata(iep_rdata), .src_enable_ext(ext_en),
    .src_prio_high(prio), .src_pending(pend), .ext0_edge_mode(edge_m),
    .ext1_edge_mode(edge_m), .ext_input0_pending_clr(clr0),
    .ext_input1_pending_clr(clr1), .instr_done(instr_done),
    .return_from_interrupt(rfi), .long_call_done(done), .long_call_req(req),
    .service_routine_vec(vec), .active_level(lvl));
  mid_cpu_model CPU (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .long_call_req(req), .call_len(call_len), .long_call_done(done));
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      give_verdict();
    end
  end
  task give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task step;
    @(posedge sys_clk);
    #1;
  endtask
  task wr(input logic [7:0] d);
    iep_wdata = d;
    iep_wr = 1'b1;
    step;
    iep_wr = 1'b0;
    `CHK("iep", d, iep_rdata)
  endtask
  task serve(input logic [14:0] m, input logic [15:0] ev,
             input logic [1:0] el);
    logic [1:0] ec;
    pend = m;
    instr_done = 1'b1;
    step;
    instr_done = 1'b0;
    `CHK("req", 1'b1, req)
    `CHK("vec", ev, vec)
    for (int n = 0; n < 12 && !done; n++) step;
    step;
    pend = 15'h0000;
    `CHK("req_off", 1'b0, req)
    `CHK("level", el, lvl)
    ec = {ev == 16'h0013, ev == 16'h0003} & {2{edge_m}};
    `CHK("clr", ec, {clr1, clr0})
  endtask
  task refuse(input logic [14:0] m);
    pend = m;
    instr_done = 1'b1;
    step;
    instr_done = 1'b0;
    `CHK("refused", 1'b0, req)
    pend = 15'h0000;
    step;
  endtask
  task ret(input logic [1:0] el);
    rfi = 1'b1;
    step;
    rfi = 1'b0;
    `CHK("ret_level", el, lvl)
    instr_done = 1'b1;
    step;
    instr_done = 1'b0;
    step;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    `CHK("rst", 27'h0, {iep_rdata, req, vec, lvl})
    wr(8'hff);
    for (int i = 0; i < 15; i++)
      if (i != 8 && i != 13) begin
        serve(15'h0001 << i, 16'h0003 + 16'(8 * i), 2'b01);
        ret(2'b00);
      end
    serve(15'h0005, 16'h0003, 2'b01);
    refuse(15'h0002);
    prio = 15'h0010;
    serve(15'h0010, 16'h0023, 2'b11);
    refuse(15'h0010);
    ret(2'b01);
    ret(2'b00);
    call_len = 4'h7;
    serve(15'h0004, 16'h0013, 2'b01);
    step;
    pend = 15'h0004;
    rfi = 1'b1;
    step;
    rfi = 1'b0;
    `CHK("no_call_on_ret", 1'b0, req)
    // a long instruction runs after the return
    repeat (7) step;
    `CHK("wait_instr", 1'b0, req)
    serve(15'h0004, 16'h0013, 2'b01);
    ret(2'b00);
    edge_m = 1'b0;
    serve(15'h0001, 16'h0003, 2'b01);
    ret(2'b00);
    edge_m = 1'b1;
    ext_en = 15'h7f7f;
    refuse(15'h0080);
    wr(8'h7f);
    refuse(15'h0001);
    give_verdict();
  end
endmodule // mid_dispatch_tb_top
`default_nettype wire
